// File: bpg_pkg.sv
`default_nettype none
package bpg_pkg;
   // register map, byte addresses on the bus
   localparam logic [15:0] BPG_REG_ADDR  = 16'hf050;
   localparam logic [15:0] BPG_STAT_ADDR = 16'hf054;
   localparam logic [15:0] BPG_REG_RESET = 16'h0000;

   // enable bit positions
   localparam int unsigned BPG_PRECISE_BIT = 12;
   localparam int unsigned BPG_SECOND_BIT  = 11;
   localparam int unsigned BPG_FIRST_BIT   = 10;
   localparam int unsigned BPG_UPPER_BIT   = 9;
   localparam int unsigned BPG_LOWER_BIT   = 8;
   localparam int unsigned BPG_SOUT_LSB    = 4;
   localparam int unsigned BPG_SIN_LSB     = 0;

   // status register fields
   localparam int unsigned BPG_STAT_BCLK_LSB  = 0;
   localparam int unsigned BPG_STAT_FRAME_LSB = 3;

   // sizes
   localparam int unsigned BPG_NUM_GEN  = 3;
   localparam int unsigned BPG_NUM_PINS = 4;
   localparam int unsigned BPG_NUM_FUNC = 4;
   localparam int unsigned BPG_NUM_CONV = 8;
   localparam int unsigned BPG_NUM_CHAN = 16;

   // generator timing: half periods in system clock cycles, frame half period in bit clocks
   localparam int unsigned BPG_GEN_HALF [3] = '{4, 6, 2};
   localparam int unsigned BPG_FRAME_HALF_BITS = 32;

   typedef enum logic [1:0] {
      BPG_SRC_NONE,
      BPG_SRC_FIRST,
      BPG_SRC_SECOND,
      BPG_SRC_PRECISE
   } bpg_src_t;
endpackage
`default_nettype wire

// File: bpg_clkgen_if.sv
`timescale 1ns/10ps
`default_nettype none
interface bpg_clkgen_if;
   logic enable;
   logic ce;
   logic bit_clk;
   logic frame_clk;

   modport gen (input enable, input ce, output bit_clk, output frame_clk);
   modport ctl (output enable, output ce, input bit_clk, input frame_clk);
endinterface
`default_nettype wire

// File: bpg_clkgen.sv
`timescale 1ns/10ps
`default_nettype none
module bpg_clkgen #(
   parameter int unsigned HALF = 4
) (
   // clock and reset
   input  wire logic      clk_sys_i,
   input  wire logic      reset_i,
   // control and clocks
   bpg_clkgen_if.gen      gen
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [5:0] bits_q;
   logic [5:0] bits_d;
   logic       bclk_q;
   logic       bclk_d;
   logic       frame_q;
   logic       frame_d;

   always_comb begin
      cnt_d   = cnt_q;
      bits_d  = bits_q;
      bclk_d  = bclk_q;
      frame_d = frame_q;
      if (!gen.enable) begin
         // held in reset while gated, so clocks restart from a clean phase
         cnt_d   = 8'h00; // [RULE3] [RULE5] [RULE7]
         bits_d  = 6'h00;
         bclk_d  = 1'b0;
         frame_d = 1'b0;
      end else if (cnt_q == 8'(HALF - 1)) begin
         cnt_d  = 8'h00;
         bclk_d = !bclk_q; // [RULE12]
         if (bclk_q) begin
            if (bits_q == 6'(bpg_pkg::BPG_FRAME_HALF_BITS - 1)) begin
               bits_d  = 6'h00;
               frame_d = !frame_q;
            end else begin
               bits_d = bits_q + 6'h01;
            end
         end
      end else begin
         cnt_d = cnt_q + 8'h01;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         cnt_q   <= 8'h00;
         bits_q  <= 6'h00;
         bclk_q  <= 1'b0;
         frame_q <= 1'b0;
      end else if (gen.ce) begin
         cnt_q   <= cnt_d;
         bits_q  <= bits_d;
         bclk_q  <= bclk_d;
         frame_q <= frame_d;
      end
   end

   assign gen.bit_clk   = bclk_q;
   assign gen.frame_clk = frame_q;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);

   a_gen_off_quiet: assert property ( // [RULE3] [RULE5] [RULE7]
      gen.ce && !gen.enable |=> !gen.bit_clk && !gen.frame_clk)
      else $error("gated generator still drives a clock");
   a_gen_toggle_rate: assert property ( // [RULE12]
      gen.ce && gen.enable && cnt_q == 8'(HALF - 1) |=> gen.bit_clk != $past(gen.bit_clk))
      else $error("enabled generator missed a bit clock edge");
   c_gen_frame_turn: cover property (gen.enable && $rose(gen.frame_clk));
endmodule
`default_nettype wire

// File: bpg_power_gate.sv
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// (RULE1) one register lets software switch generators, converter banks, serial ports off
// (RULE2) register resets to zero, every gated block starts off; one enables
// (RULE3) precise generator stops its clocks while bit 12 is clear
// (RULE4) functions clocked from the precise generator stop while it is off
// (RULE5) second generator stops, its frame and bit clock pins drive low
// (RULE6) functions clocked from the second generator stop while it is off
// (RULE7) first generator stops, its frame and bit clock pins drive low
// (RULE8) functions clocked from the first generator stop while it is off
// (RULE9) bit 9 clear disables converters four to seven, channels eight to fifteen
// (RULE10) bit 8 clear disables converters zero to three, channels zero to seven
// (RULE11) serial out enable off kills data pin only, port clocks keep running
// (RULE12) setting a bit again resumes the gated block with no more software action
module bpg_power_gate (
   // clock, reset, enable
   input  wire logic              clk_sys_i,
   input  wire logic              reset_i,
   input  wire logic              ce_i,
   // wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [15:0]       wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // clock pin routing
   input  wire bpg_pkg::bpg_src_t frame_src_i [bpg_pkg::BPG_NUM_PINS],
   input  wire bpg_pkg::bpg_src_t bit_src_i   [bpg_pkg::BPG_NUM_PINS],
   output logic      [3:0]        frame_clock_out_pin_o,
   output logic      [3:0]        frame_clock_out_pin_oe_o,
   output logic      [3:0]        bit_clock_out_pin_o,
   output logic      [3:0]        bit_clock_out_pin_oe_o,
   // functions clocked from a generator, entry 0 is the core
   input  wire bpg_pkg::bpg_src_t func_src_i  [bpg_pkg::BPG_NUM_FUNC],
   output logic      [3:0]        func_run_o,
   // rate converters
   input  wire logic [15:0]       chan_valid_i,
   output logic      [7:0]        conv_enable_o,
   output logic      [15:0]       chan_valid_o,
   // serial ports
   input  wire logic [3:0]        sdata_out_i,
   output logic      [3:0]        sdata_out_o,
   output logic      [3:0]        sdata_out_oe_o,
   output logic      [3:0]        serial_out_port_enable_o,
   output logic      [3:0]        serial_in_port_enable_o
);
   logic [15:0] reg_q;
   logic [15:0] reg_d;
   logic        ack_d;
   logic [31:0] dat_d;
   logic        req;
   logic [2:0]  gen_en;
   logic [2:0]  gen_bclk;
   logic [2:0]  gen_frame;
   logic [3:0]  fpin_d;
   logic [3:0]  fpin_oe_d;
   logic [3:0]  bpin_d;
   logic [3:0]  bpin_oe_d;
   logic [3:0]  run_d;
   logic [7:0]  conv_d;
   logic [15:0] chan_d;
   logic [3:0]  sout_d;
   logic [3:0]  sout_oe_d;
   logic [3:0]  sout_en;

   function automatic logic addr_hit(logic [15:0] adr, logic [15:0] base);
      addr_hit = (adr[15:2] == base[15:2]);
   endfunction

   // pick the generator's entry in a per-generator vector
   function automatic logic src_pick(bpg_pkg::bpg_src_t s, logic [2:0] v);
      case (s)
         bpg_pkg::BPG_SRC_FIRST:   src_pick = v[0];
         bpg_pkg::BPG_SRC_SECOND:  src_pick = v[1];
         bpg_pkg::BPG_SRC_PRECISE: src_pick = v[2];
         default:                  src_pick = 1'b0;
      endcase
   endfunction

   // a function not on any generator runs from elsewhere and is never gated
   function automatic logic func_ok(bpg_pkg::bpg_src_t s, logic [2:0] en);
      func_ok = (s == bpg_pkg::BPG_SRC_NONE) ? 1'b1 : src_pick(s, en);
   endfunction

   assign gen_en  = {reg_q[bpg_pkg::BPG_PRECISE_BIT],
                     reg_q[bpg_pkg::BPG_SECOND_BIT],
                     reg_q[bpg_pkg::BPG_FIRST_BIT]};
   assign sout_en = reg_q[bpg_pkg::BPG_SOUT_LSB +: 4];
   assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;

   bpg_clkgen_if gen_if [bpg_pkg::BPG_NUM_GEN] ();

   for (genvar g = 0; g < bpg_pkg::BPG_NUM_GEN; g++) begin : g_gen
      assign gen_if[g].enable = gen_en[g]; // [RULE3] [RULE5] [RULE7]
      assign gen_if[g].ce     = ce_i;
      assign gen_bclk[g]      = gen_if[g].bit_clk;
      assign gen_frame[g]     = gen_if[g].frame_clk;
      bpg_clkgen #(
         .HALF (bpg_pkg::BPG_GEN_HALF[g])
      ) u_gen (
         .clk_sys_i (clk_sys_i),
         .reset_i   (reset_i),
         .gen       (gen_if[g])
      );
   end

   // bus side
   always_comb begin
      reg_d = reg_q;
      ack_d = 1'b0;
      dat_d = 32'h0000_0000;
      if (req) begin
         // unmapped addresses still answer, reading zero
         ack_d = 1'b1; // [RULE1]
         if (addr_hit(wb_adr_i, bpg_pkg::BPG_REG_ADDR)) begin
            if (wb_we_i) begin
               if (wb_sel_i[0]) begin
                  reg_d[7:0] = wb_dat_i[7:0]; // [RULE1]
               end
               if (wb_sel_i[1]) begin
                  reg_d[15:8] = wb_dat_i[15:8]; // [RULE1]
               end
            end else begin
               dat_d = {16'h0000, reg_q};
            end
         end else if (addr_hit(wb_adr_i, bpg_pkg::BPG_STAT_ADDR) && !wb_we_i) begin
            dat_d[bpg_pkg::BPG_STAT_BCLK_LSB +: 3]  = gen_bclk;
            dat_d[bpg_pkg::BPG_STAT_FRAME_LSB +: 3] = gen_frame;
         end
      end
   end

   // gated outputs
   always_comb begin
      for (int p = 0; p < bpg_pkg::BPG_NUM_PINS; p++) begin
         // a pin on a gated generator is driven low, not released
         fpin_d[p]    = src_pick(frame_src_i[p], gen_frame & gen_en); // [RULE5] [RULE7]
         fpin_oe_d[p] = (frame_src_i[p] != bpg_pkg::BPG_SRC_NONE);
         bpin_d[p]    = src_pick(bit_src_i[p], gen_bclk & gen_en); // [RULE5] [RULE7]
         bpin_oe_d[p] = (bit_src_i[p] != bpg_pkg::BPG_SRC_NONE);
      end
      for (int f = 0; f < bpg_pkg::BPG_NUM_FUNC; f++) begin
         run_d[f] = func_ok(func_src_i[f], gen_en); // [RULE4] [RULE6] [RULE8] [RULE12]
      end
      conv_d[3:0]  = {4{reg_q[bpg_pkg::BPG_LOWER_BIT]}}; // [RULE10]
      conv_d[7:4]  = {4{reg_q[bpg_pkg::BPG_UPPER_BIT]}}; // [RULE9]
      chan_d[7:0]  = chan_valid_i[7:0] & {8{reg_q[bpg_pkg::BPG_LOWER_BIT]}}; // [RULE10] [RULE12]
      chan_d[15:8] = chan_valid_i[15:8] & {8{reg_q[bpg_pkg::BPG_UPPER_BIT]}}; // [RULE9] [RULE12]
      // serial enables touch only the data path, never the clock pins
      sout_d       = sdata_out_i & sout_en; // [RULE11]
      sout_oe_d    = sout_en; // [RULE11]
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         reg_q                    <= bpg_pkg::BPG_REG_RESET; // [RULE2]
         wb_ack_o                 <= 1'b0;
         wb_dat_o                 <= 32'h0000_0000;
         frame_clock_out_pin_o    <= 4'h0;
         frame_clock_out_pin_oe_o <= 4'h0;
         bit_clock_out_pin_o      <= 4'h0;
         bit_clock_out_pin_oe_o   <= 4'h0;
         func_run_o               <= 4'h0;
         conv_enable_o            <= 8'h00;
         chan_valid_o             <= 16'h0000;
         sdata_out_o              <= 4'h0;
         sdata_out_oe_o           <= 4'h0;
         serial_out_port_enable_o <= 4'h0;
         serial_in_port_enable_o  <= 4'h0;
      end else if (ce_i) begin
         reg_q                    <= reg_d;
         wb_ack_o                 <= ack_d;
         wb_dat_o                 <= dat_d;
         frame_clock_out_pin_o    <= fpin_d;
         frame_clock_out_pin_oe_o <= fpin_oe_d;
         bit_clock_out_pin_o      <= bpin_d;
         bit_clock_out_pin_oe_o   <= bpin_oe_d;
         func_run_o               <= run_d;
         conv_enable_o            <= conv_d;
         chan_valid_o             <= chan_d;
         sdata_out_o              <= sout_d;
         sdata_out_oe_o           <= sout_oe_d;
         serial_out_port_enable_o <= sout_en; // [RULE11]
         serial_in_port_enable_o  <= reg_q[bpg_pkg::BPG_SIN_LSB +: 4];
      end
   end

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);

   a_reg_reset_zero: assert property ( // [RULE2]
      $past(reset_i) |-> reg_q == bpg_pkg::BPG_REG_RESET && func_run_o == 4'h0)
      else $error("enable register not zero after reset");

   a_reg_write_take: assert property ( // [RULE1]
      ce_i && req && wb_we_i && wb_sel_i[1:0] == 2'h3
      && addr_hit(wb_adr_i, bpg_pkg::BPG_REG_ADDR)
      |=> reg_q == $past(wb_dat_i[15:0]) && wb_ack_o)
      else $error("register write not taken with ack");

   a_wb_ack_single: assert property ( // [RULE1]
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   a_core_stop_prec: assert property ( // [RULE4]
      ce_i && !reg_q[bpg_pkg::BPG_PRECISE_BIT]
      && func_src_i[0] == bpg_pkg::BPG_SRC_PRECISE |=> !func_run_o[0])
      else $error("core runs with precise generator off");

   a_core_stop_second: assert property ( // [RULE6]
      ce_i && !reg_q[bpg_pkg::BPG_SECOND_BIT]
      && func_src_i[0] == bpg_pkg::BPG_SRC_SECOND |=> !func_run_o[0])
      else $error("core runs with second generator off");

   a_core_stop_first: assert property ( // [RULE8]
      ce_i && !reg_q[bpg_pkg::BPG_FIRST_BIT]
      && func_src_i[0] == bpg_pkg::BPG_SRC_FIRST |=> !func_run_o[0])
      else $error("core runs with first generator off");

   a_frame_pin_low: assert property ( // [RULE5]
      ce_i && !reg_q[bpg_pkg::BPG_SECOND_BIT]
      && frame_src_i[0] == bpg_pkg::BPG_SRC_SECOND
      |=> !frame_clock_out_pin_o[0] && frame_clock_out_pin_oe_o[0])
      else $error("frame pin not driven low on gated generator");

   a_bit_pin_low: assert property ( // [RULE7]
      ce_i && !reg_q[bpg_pkg::BPG_FIRST_BIT]
      && bit_src_i[0] == bpg_pkg::BPG_SRC_FIRST
      |=> !bit_clock_out_pin_o[0] && bit_clock_out_pin_oe_o[0])
      else $error("bit pin not driven low on gated generator");

   a_upper_bank_off: assert property ( // [RULE9]
      ce_i && !reg_q[bpg_pkg::BPG_UPPER_BIT]
      |=> chan_valid_o[15:8] == 8'h00 && conv_enable_o[7:4] == 4'h0)
      else $error("upper converter bank active while gated");

   a_lower_bank_off: assert property ( // [RULE10]
      ce_i && !reg_q[bpg_pkg::BPG_LOWER_BIT]
      |=> chan_valid_o[7:0] == 8'h00 && conv_enable_o[3:0] == 4'h0)
      else $error("lower converter bank active while gated");

   a_sout_gate: assert property ( // [RULE11]
      ce_i && !reg_q[bpg_pkg::BPG_SOUT_LSB]
      |=> !sdata_out_o[0] && !sdata_out_oe_o[0])
      else $error("serial data pin active while gated");

   a_bank_resume: assert property ( // [RULE12]
      ce_i && reg_q[bpg_pkg::BPG_LOWER_BIT]
      |=> chan_valid_o[7:0] == $past(chan_valid_i[7:0]))
      else $error("lower bank does not pass data when enabled");

   a_upper_bank_pass: assert property ( // [RULE12]
      ce_i && reg_q[bpg_pkg::BPG_UPPER_BIT]
      |=> chan_valid_o[15:8] == $past(chan_valid_i[15:8]) && conv_enable_o[7:4] == 4'hf)
      else $error("upper bank does not pass data when enabled");

   a_frame_pin_first: assert property ( // [RULE7]
      ce_i && !reg_q[bpg_pkg::BPG_FIRST_BIT]
      && frame_src_i[1] == bpg_pkg::BPG_SRC_FIRST
      |=> !frame_clock_out_pin_o[1] && frame_clock_out_pin_oe_o[1])
      else $error("frame pin not driven low on gated first generator");

   a_bit_pin_second: assert property ( // [RULE5]
      ce_i && !reg_q[bpg_pkg::BPG_SECOND_BIT]
      && bit_src_i[1] == bpg_pkg::BPG_SRC_SECOND
      |=> !bit_clock_out_pin_o[1] && bit_clock_out_pin_oe_o[1])
      else $error("bit pin not driven low on gated second generator");

   a_pin_prec_low: assert property ( // [RULE3]
      ce_i && !reg_q[bpg_pkg::BPG_PRECISE_BIT]
      && bit_src_i[2] == bpg_pkg::BPG_SRC_PRECISE
      |=> !bit_clock_out_pin_o[2])
      else $error("bit pin toggles with precise generator off");

   a_core_resume: assert property ( // [RULE12]
      ce_i && reg_q[bpg_pkg::BPG_FIRST_BIT]
      && func_src_i[0] == bpg_pkg::BPG_SRC_FIRST |=> func_run_o[0])
      else $error("core stays stopped with first generator on");

   a_func_free_run: assert property ( // [RULE4] [RULE6] [RULE8]
      ce_i && func_src_i[3] == bpg_pkg::BPG_SRC_NONE |=> func_run_o[3])
      else $error("function off any generator was stopped");

   a_sout_pass: assert property ( // [RULE11]
      ce_i && reg_q[bpg_pkg::BPG_SOUT_LSB]
      |=> sdata_out_o[0] == $past(sdata_out_i[0]) && sdata_out_oe_o[0])
      else $error("enabled serial data pin does not pass data");

   a_sin_follow: assert property ( // [RULE1]
      ce_i |=> serial_in_port_enable_o == $past(reg_q[bpg_pkg::BPG_SIN_LSB +: 4]))
      else $error("serial in enables do not follow the register");

   a_unmapped_zero: assert property ( // [RULE1]
      ce_i && req && !wb_we_i && !addr_hit(wb_adr_i, bpg_pkg::BPG_REG_ADDR)
      && !addr_hit(wb_adr_i, bpg_pkg::BPG_STAT_ADDR)
      |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
      else $error("unmapped read did not answer with zero");

   a_dat_idle_zero: assert property ( // [RULE1]
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data shown without ack");

   c_reg_write: cover property (
      req && wb_we_i && addr_hit(wb_adr_i, bpg_pkg::BPG_REG_ADDR));
   c_core_stopped: cover property (
      func_src_i[0] == bpg_pkg::BPG_SRC_PRECISE ##1 $fell(func_run_o[0]));
   c_pin_toggle: cover property ($rose(bit_clock_out_pin_o[0]));
   c_bank_resume: cover property ($rose(conv_enable_o[0]));
endmodule
`default_nettype wire

// File: bpg_power_gate_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bpg_power_gate_tb;
   logic              clk_sys_i, reset_i, ce_i, cyc, stb, we, ack;
   logic [15:0]       adr, cv_i, cv_o, m;
   logic [3:0]        sel, sd_i, fpin, foe, bpin, boe, run, sd_o, sd_oe, so_en, si_en;
   logic [31:0]       dat, dat_o, rd;
   logic [7:0]        conv;
   bpg_pkg::bpg_src_t fsrc [bpg_pkg::BPG_NUM_PINS];
   bpg_pkg::bpg_src_t bsrc [bpg_pkg::BPG_NUM_PINS];
   bpg_pkg::bpg_src_t usrc [bpg_pkg::BPG_NUM_FUNC];
   int                fails, checked, seed;

   bpg_power_gate i_bpg_power_gate (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .frame_src_i(fsrc), .bit_src_i(bsrc), .frame_clock_out_pin_o(fpin),
      .frame_clock_out_pin_oe_o(foe), .bit_clock_out_pin_o(bpin), .bit_clock_out_pin_oe_o(boe),
      .func_src_i(usrc), .func_run_o(run), .chan_valid_i(cv_i), .conv_enable_o(conv),
      .chan_valid_o(cv_o), .sdata_out_i(sd_i), .sdata_out_o(sd_o), .sdata_out_oe_o(sd_oe),
      .serial_out_port_enable_o(so_en), .serial_in_port_enable_o(si_en));

   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end

   // generator feeding a source is running
   function automatic logic on(bpg_pkg::bpg_src_t s);
      return s != bpg_pkg::BPG_SRC_NONE && m[bpg_pkg::BPG_FIRST_BIT + int'(s) - 1];
   endfunction

   task automatic finish_test();
      if (fails == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rst();
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      m = 16'h0000;
   endtask

   // one classic cycle; gap holds ce_i low for that many edges of the request
   task automatic wb(input logic w, input logic [15:0] a, input logic [3:0] s, input logic [31:0] d, input int gap);
      int n;
      @(posedge clk_sys_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      if (gap > 0) ce_i <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
         if (n == gap) ce_i <= 1'b1;
      end while (ack !== 1'b1 && n < 50);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (w && a[15:2] == bpg_pkg::BPG_REG_ADDR[15:2]) begin
         if (s[0]) m[7:0] = d[7:0];
         if (s[1]) m[15:8] = d[15:8];
      end
      chk({ack, n > gap + 1}, 2'b11);
   endtask

   task automatic chk_out();
      logic [3:0] ef, eb, er;
      for (int p = 0; p < 4; p++) begin
         ef[p] = fsrc[p] != bpg_pkg::BPG_SRC_NONE;
         eb[p] = bsrc[p] != bpg_pkg::BPG_SRC_NONE;
         er[p] = usrc[p] == bpg_pkg::BPG_SRC_NONE || on(usrc[p]);
      end
      chk({foe, boe}, {ef, eb});
      chk(run, er);
      chk(conv, {{4{m[9]}}, {4{m[8]}}});
      chk(cv_o, cv_i & {{8{m[9]}}, {8{m[8]}}});
      chk({sd_o, sd_oe, so_en, si_en}, {sd_i & m[7:4], m[7:4], m[7:4], m[3:0]});
   endtask

   // pins of a running generator must toggle, pins of a gated one stay low
   task automatic win(input int len);
      logic [3:0] fh, fl, bh, bl, ef, eb;
      fh = 4'h0;
      fl = 4'h0;
      bh = 4'h0;
      bl = 4'h0;
      repeat (len) begin
         @(posedge clk_sys_i);
         fh = fh | fpin;
         fl = fl | ~fpin;
         bh = bh | bpin;
         bl = bl | ~bpin;
      end
      for (int p = 0; p < 4; p++) begin
         ef[p] = on(fsrc[p]);
         eb[p] = on(bsrc[p]);
      end
      chk({fh, bh}, {ef, eb});
      chk({fl, bl}, 8'hff);
   endtask

   initial begin
      seed = 12568;
      fails = 0;
      checked = 0;
      m = 16'h0000;
      ce_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 16'h0000;
      sel = 4'h0;
      dat = 32'h0;
      cv_i = 16'h0000;
      sd_i = 4'h0;
      for (int p = 0; p < 4; p++) begin
         fsrc[p] = bpg_pkg::BPG_SRC_NONE;
         bsrc[p] = bpg_pkg::BPG_SRC_NONE;
         usrc[p] = bpg_pkg::BPG_SRC_NONE;
      end
      rst();
      for (int i = 0; i < 8; i++) begin
         for (int p = 0; p < 4; p++) begin
            fsrc[p] <= bpg_pkg::bpg_src_t'(2'($random(seed)));
            bsrc[p] <= bpg_pkg::bpg_src_t'(2'($random(seed)));
            usrc[p] <= bpg_pkg::bpg_src_t'(2'($random(seed)));
         end
         cv_i <= 16'($random(seed));
         sd_i <= 4'($random(seed));
         if (i == 5) begin
            rst();
         end else if (i > 0) begin
            wb(1'b1, bpg_pkg::BPG_REG_ADDR, i < 4 ? 4'h3 : 4'($random(seed)),
               (i == 1 || i == 3) ? 32'hffff : (i == 2 ? 32'h0 : $random(seed)), i == 4 ? 3 : 0);
         end
         wb(1'b1, bpg_pkg::BPG_STAT_ADDR, 4'hf, $random(seed), 0);
         wb(1'b0, bpg_pkg::BPG_REG_ADDR, 4'hf, 32'h0, 0);
         chk(rd, {16'h0000, m});
         wb(1'b0, bpg_pkg::BPG_STAT_ADDR, 4'hf, 32'h0, 0);
         chk(rd & ~{26'h0, m[12:10], m[12:10]}, 32'h0);
         wb(1'b0, 16'hf058, 4'hf, 32'h0, 0);
         chk(rd, 32'h0);
         repeat (2) @(posedge clk_sys_i);
         chk_out();
         win(900);
      end
      finish_test();
   end

   initial begin
      #800000;
      fails++;
      finish_test();
   end
endmodule
`default_nettype wire
